// >>> hdl/mmb_bus_ctrl.sv
// Minimum-mode local bus control generator with hold handshake.
//
// Overview of operation
// - Queue code shown clock after queue event.
// - Codes: none, first, flush, subsequent byte.
// - Strap high enables minimum-mode control outputs.
// - Memory/IO select high memory, low IO.
// - Select valid from T1 through T4.
// - Float select, write, direction, enable when granted.
// - Write strobe low in T2, T3 and waits.
// - Acknowledge strobe low T2, T3, waits.
// - Latch pulse high in T1, never floated.
// - Direction high transmit, same window as select.
// - Enable mid-T2 to mid-T4 for reads, acknowledges.
// - Enable start T2 to mid-T4 for writes.
// - Grant rises at the end of a T4 or idle clock, floating outputs.
// - Drop grant on low request; drive again later.
`timescale 1ns/1ps
`include "mmb_regs.svh"
module mmb_bus_ctrl (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Configuration strap, high selects minimum mode.
   input wire logic config_strap_in,
   // Internal transfer request.
   input wire logic xfer_req_in,
   input wire mmb_pkg::mmb_kind_t xfer_kind_in,
   input wire logic xfer_mem_in,
   output logic xfer_ack_out,
   // Memory ready; low inserts wait states.
   input wire logic ready_in,
   // Internal queue events.
   input wire logic q_take_first_in,
   input wire logic q_take_next_in,
   input wire logic q_flush_in,
   // Hold handshake.
   input wire logic hold_req_in,
   output logic bus_yield_grant_out,
   // Bus control outputs with output enables.
   output logic mem_io_sel_out,
   output logic mem_io_sel_oe_out,
   output logic wr_strobe_n_out,
   output logic wr_strobe_n_oe_out,
   output logic irq_ack_strobe_n_out,
   output logic irq_ack_strobe_n_oe_out,
   output logic addr_latch_out,
   output logic xcvr_direction_out,
   output logic xcvr_direction_oe_out,
   output logic xcvr_output_enable_n_out,
   output logic xcvr_output_enable_n_oe_out,
   output logic [1:0] queue_track_code_out,
   output logic mode_min_out
);
   import mmb_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   mmb_state_t state_q; // Present bus state.
   mmb_state_t state_d; // Next bus state.
   logic strap_q; // Strap caught after reset release.
   logic strap_seen_q; // Strap capture done.
   logic grant_q; // Bus given away.
   logic grant_d; // Next grant.
   mmb_kind_t kind_q; // Kind of the running cycle.
   logic float_q; // Lines left floating until the next cycle starts.
   logic float_d; // Next float state.
   logic sel_q; // Registered memory/IO select.
   logic dir_q; // Registered transceiver direction.
   logic wr_n_q; // Registered write strobe.
   logic ack_n_q; // Registered acknowledge strobe.
   logic ale_q; // Registered latch pulse.
   logic en_rise_q; // Enable captured on rising edge.
   logic en_fall_q; // Enable captured on falling edge for mid points.
   logic start_ok; // A new cycle may begin.
   logic hold_ok; // Hold may be granted now.
   logic is_write; // Running cycle writes.
   logic is_ack; // Running cycle is acknowledge.
   logic drive_en; // Outputs driven in minimum mode.
   mmb_q_if qi (); // Queue event carrier.

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Hold is only taken at a T4 or idle boundary.
   assign hold_ok = hold_req_in && (state_q == MMB_T4 ||
                                    state_q == MMB_TI);
   // A cycle starts from T4 or idle when no hold is taken.
   assign start_ok = xfer_req_in && !hold_ok && !grant_q &&
                     (state_q == MMB_T4 || state_q == MMB_TI);
   assign is_write = (kind_q == MMB_WR);
   assign is_ack = (kind_q == MMB_ACK);
   // Floating starts with the grant and ends only when a new cycle is
   // accepted, so a released bus is not driven while nothing is pending.
   assign float_d = (grant_d && strap_q) ||
                    (float_q && !start_ok);
   assign drive_en = strap_q && !grant_q && !float_q;
   assign xfer_ack_out = start_ok && strap_q;

   // Next state of the bus sequencer.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         MMB_TI: state_d = (start_ok && strap_q) ? MMB_T1 : MMB_TI;
         MMB_T1: state_d = MMB_T2;
         MMB_T2: state_d = MMB_T3;
         MMB_T3: state_d = ready_in ? MMB_T4 : MMB_TW;
         MMB_TW: state_d = ready_in ? MMB_T4 : MMB_TW;
         MMB_T4: state_d = (start_ok && strap_q) ? MMB_T1 : MMB_TI;
         default: state_d = MMB_TI;
      endcase
   end

   // Grant follows the hold request at T4/idle; released on low.
   assign grant_d = grant_q ? hold_req_in : hold_ok;

   // ----------------------------------------------------------------
   // Sequencer and strap
   // ----------------------------------------------------------------
   // Strap captured once in the clock after reset release.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strap_q <= 1'b0;
         strap_seen_q <= 1'b0;
      end else if (!strap_seen_q) begin
         strap_q <= config_strap_in;
         strap_seen_q <= 1'b1;
      end
   end

   // State, grant and captured cycle attributes.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= MMB_TI;
         grant_q <= 1'b0;
         kind_q <= MMB_RD;
         float_q <= 1'b0;
      end else begin
         state_q <= state_d;
         grant_q <= grant_d && strap_q;
         float_q <= float_d;
         if (start_ok) begin
            kind_q <= xfer_kind_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control outputs
   // ----------------------------------------------------------------
   // Select and direction update when a cycle is accepted, so they are
   // valid from the following T1 through the closing T4.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sel_q <= 1'b1;
         dir_q <= 1'b0;
      end else if (start_ok) begin
         sel_q <= xfer_mem_in && (xfer_kind_in != MMB_ACK);
         dir_q <= (xfer_kind_in == MMB_WR);
      end
   end

   // Strobes and latch pulse are registered from the next state.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_n_q <= 1'b1;
         ack_n_q <= 1'b1;
         ale_q <= 1'b0;
         en_rise_q <= 1'b1;
      end else begin
         ale_q <= (state_d == MMB_T1);
         wr_n_q <= !(is_write && (state_d == MMB_T2 ||
                     state_d == MMB_T3 || state_d == MMB_TW));
         ack_n_q <= !(is_ack && (state_d == MMB_T2 ||
                      state_d == MMB_T3 || state_d == MMB_TW));
         // Rising stage covers T2 to the end of T3/waits; the falling
         // stage carries the enable on to mid-T4.
         en_rise_q <= !(is_write && (state_d == MMB_T2 ||
                        state_d == MMB_T3 ||
                        state_d == MMB_TW));
      end
   end

   // Falling-edge stage gives the mid-T2 start and mid-T4 end.
   always_ff @(negedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         en_fall_q <= 1'b1;
      end else begin
         en_fall_q <= !(state_q == MMB_T2 || state_q == MMB_T3 ||
                        state_q == MMB_TW);
      end
   end

   // ----------------------------------------------------------------
   // Queue tracking
   // ----------------------------------------------------------------
   assign qi.take_first = q_take_first_in;
   assign qi.take_next = q_take_next_in;
   assign qi.flush = q_flush_in;
   mmb_queue_track u_qtrack (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .q(qi.enc)
   );

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   assign mode_min_out = strap_q;
   assign bus_yield_grant_out = grant_q;
   assign queue_track_code_out = qi.code;
   assign addr_latch_out = strap_q && ale_q;
   assign mem_io_sel_out = sel_q;
   assign xcvr_direction_out = dir_q;
   assign wr_strobe_n_out = wr_n_q;
   assign irq_ack_strobe_n_out = ack_n_q;
   // Writes open at T2 start; reads use the falling-edge window.
   assign xcvr_output_enable_n_out = is_write ? (en_rise_q && en_fall_q)
                                     : en_fall_q;
   assign mem_io_sel_oe_out = drive_en;
   assign wr_strobe_n_oe_out = drive_en;
   assign irq_ack_strobe_n_oe_out = drive_en;
   assign xcvr_direction_oe_out = drive_en;
   assign xcvr_output_enable_n_oe_out = drive_en;
endmodule : mmb_bus_ctrl

// >>> hdl/mmb_regs.svh
// Encodings for the minimum-mode bus control block.
`ifndef MMB_REGS_SVH
`define MMB_REGS_SVH
// Queue tracking codes.
`define MMB_QS_NONE 2'h0
`define MMB_QS_FIRST 2'h1
`define MMB_QS_FLUSH 2'h2
`define MMB_QS_NEXT 2'h3
// Cycle kinds.
`define MMB_KIND_RD 2'h0
`define MMB_KIND_WR 2'h1
`define MMB_KIND_ACK 2'h2
`endif

// >>> hdl/mmb_pkg.sv
// Types shared by the minimum-mode bus control modules.
package mmb_pkg;
   // Bus cycle states.
   typedef enum logic [2:0] {
      MMB_TI = 3'h0,
      MMB_T1 = 3'h1,
      MMB_T2 = 3'h2,
      MMB_T3 = 3'h3,
      MMB_TW = 3'h4,
      MMB_T4 = 3'h5
   } mmb_state_t;
   // Kind of transfer requested.
   typedef enum logic [1:0] {
      MMB_RD = 2'h0,
      MMB_WR = 2'h1,
      MMB_ACK = 2'h2
   } mmb_kind_t;
endpackage : mmb_pkg

// >>> hdl/mmb_q_if.sv
// Interface carrying queue operation events between modules.
`timescale 1ns/1ps
interface mmb_q_if;
   logic take_first; // Opcode byte taken this clock.
   logic take_next; // Subsequent byte taken this clock.
   logic flush; // Queue emptied this clock.
   logic [1:0] code; // Registered tracking code.
   modport src (output take_first, output take_next, output flush,
                input code);
   modport enc (input take_first, input take_next, input flush,
                output code);
endinterface : mmb_q_if

// >>> hdl/mmb_queue_track.sv
// Queue tracking code encoder, one clock after the queue event.
`timescale 1ns/1ps
`include "mmb_regs.svh"
module mmb_queue_track (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Queue events in, code out.
   mmb_q_if.enc q
);
   import mmb_pkg::*;
   logic [1:0] code_d; // Next code.
   logic [1:0] code_q; // Code shown during the following clock.

   // Flush outranks byte takes; first byte outranks subsequent.
   assign code_d = q.flush ? `MMB_QS_FLUSH :
                   q.take_first ? `MMB_QS_FIRST :
                   q.take_next ? `MMB_QS_NEXT : `MMB_QS_NONE;

   // Register the code so it shows in the clock after the event.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         code_q <= `MMB_QS_NONE;
      end else begin
         code_q <= code_d;
      end
   end
   assign q.code = code_q;
endmodule : mmb_queue_track

// >>> testbench/mmb_bus_ctrl_assertions.sv
// Checker of bus control timing at the block's ports.
`timescale 1ns/1ps
module mmb_chk (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic xfer_ack_out,
   input wire mmb_pkg::mmb_kind_t xfer_kind_in,
   input wire logic xfer_mem_in,
   input wire logic hold_req_in,
   input wire logic bus_yield_grant_out,
   input wire logic mem_io_sel_out,
   input wire logic mem_io_sel_oe_out,
   input wire logic wr_strobe_n_out,
   input wire logic wr_strobe_n_oe_out,
   input wire logic irq_ack_strobe_n_out,
   input wire logic addr_latch_out,
   input wire logic xcvr_direction_out,
   input wire logic xcvr_direction_oe_out,
   input wire logic xcvr_output_enable_n_oe_out,
   input wire logic q_take_first_in,
   input wire logic q_take_next_in,
   input wire logic q_flush_in,
   input wire logic [1:0] queue_track_code_out
);
   import mmb_pkg::*;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   // Expected codes and levels, worked out from the inputs.
   logic [1:0] q_exp;
   logic sel_exp;
   logic is_wr;
   assign q_exp = q_flush_in ? 2'h2 : q_take_first_in ? 2'h1 :
      q_take_next_in ? 2'h3 : 2'h0;
   assign sel_exp = xfer_mem_in && xfer_kind_in != MMB_ACK;
   assign is_wr = xfer_kind_in == MMB_WR;
   // Acknowledge strobe low across T2 and T3.
   sequence s_ack_low;
      !irq_ack_strobe_n_out [*2];
   endsequence
   a_latch_pulse: assert property (addr_latch_out |=> !addr_latch_out)
      else $error("latch pulse longer than one clock");
   a_ack_to_t1: assert property (xfer_ack_out |=> addr_latch_out)
      else $error("accepted cycle did not enter T1");
   a_wr_in_t2: assert property (xfer_ack_out && is_wr |-> ##2 !wr_strobe_n_out)
      else $error("write strobe not low in T2");
   a_irq_ack_low: assert property (xfer_ack_out && xfer_kind_in == MMB_ACK |-> ##2 s_ack_low)
      else $error("acknowledge strobe not low in T2 and T3");
   a_sel_kind: assert property (xfer_ack_out |=> mem_io_sel_out == $past(sel_exp))
      else $error("select level wrong for the cycle");
   a_dir_kind: assert property (xfer_ack_out |=> xcvr_direction_out == $past(is_wr))
      else $error("direction level wrong for the cycle");
   a_grant_float: assert property (bus_yield_grant_out |-> !(mem_io_sel_oe_out || wr_strobe_n_oe_out || xcvr_direction_oe_out || xcvr_output_enable_n_oe_out))
      else $error("control line driven while granted");
   a_grant_drop: assert property (bus_yield_grant_out && !hold_req_in |=> !bus_yield_grant_out)
      else $error("grant held after request fell");
   a_float_held: assert property ($fell(bus_yield_grant_out) |-> !mem_io_sel_oe_out)
      else $error("lines driven again before a cycle was needed");
   a_queue_code: assert property (queue_track_code_out == $past(q_exp))
      else $error("queue code wrong one clock after event");
endmodule // mmb_chk
bind mmb_bus_ctrl mmb_chk chk_u (.*);

// >>> testbench/mmb_far_model.sv
// Far-side model: memory ready with wait states and a second bus master.
`timescale 1ns/1ps
module mmb_far_model (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic addr_latch_in,
   input wire logic [3:0] wait_cnt_in,
   input wire logic hold_want_in,
   output logic ready_out,
   output logic hold_req_out
);
   logic [4:0] cnt_q; // Clocks left before ready returns.
   assign ready_out = (cnt_q == 5'h0);
   // Load the wait count at T1 and count down through T2, T3 and waits.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= 5'h0;
         hold_req_out <= 1'b0;
      end else begin
         // Held high for as long as the bus is wanted.
         hold_req_out <= hold_want_in; // Launched on the clock.
         if (addr_latch_in) begin
            cnt_q <= {1'b0, wait_cnt_in} + 5'h1;
         end else if (cnt_q != 5'h0) begin
            cnt_q <= cnt_q - 5'h1;
         end
      end
   end
endmodule // mmb_far_model

// >>> testbench/test_min_mode_local_bus_control.sv
// Self-checking bench for the minimum-mode bus control block.
`timescale 1ns/1ps
module test_min_mode_local_bus_control;
   import mmb_pkg::*;
   logic ref_clk_in = 1'b0, arst_n_in = 1'b0, config_strap_in = 1'b0;
   logic xfer_req_in = 1'b0, xfer_mem_in = 1'b0, hold_want = 1'b0;
   logic q_take_first_in = 1'b0, q_take_next_in = 1'b0, q_flush_in = 1'b0;
   mmb_kind_t xfer_kind_in = MMB_RD;
   logic [3:0] wait_cnt = 4'h0;
   logic ready_in, hold_req_in, xfer_ack_out, bus_yield_grant_out;
   logic mem_io_sel_out, mem_io_sel_oe_out, wr_strobe_n_out;
   logic wr_strobe_n_oe_out, irq_ack_strobe_n_out, irq_ack_strobe_n_oe_out;
   logic addr_latch_out, xcvr_direction_out, xcvr_direction_oe_out;
   logic xcvr_output_enable_n_out, xcvr_output_enable_n_oe_out, mode_min_out;
   logic [1:0] queue_track_code_out;
   int err_total = 0, checks_done = 0;
   always #10 ref_clk_in = ~ref_clk_in;
   mmb_bus_ctrl dut_u (.*);
   mmb_far_model far_u (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .addr_latch_in(addr_latch_out), .wait_cnt_in(wait_cnt),
      .hold_want_in(hold_want), .ready_out(ready_in),
      .hold_req_out(hold_req_in));
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Wait, bounded, for acknowledge (sel 0) or grant (sel 1) to reach lvl.
   task automatic wait_lvl(input int sel, input logic lvl);
      int n;
      n = 0;
      // Look 1 ns after the edge so a combinational answer has settled.
      #1;
      while ((sel ? bus_yield_grant_out : xfer_ack_out) !== lvl) begin
         @(negedge ref_clk_in);
         #1;
         if (++n > 40) begin
            err_total++;
            complete_run();
         end
      end
   endtask
   // One bus cycle of kind k with w wait states, checked state by state.
   task automatic do_cycle(input mmb_kind_t k, input logic m,
                           input logic [3:0] w);
      logic wrc, akc;
      wrc = (k == MMB_WR);
      akc = (k == MMB_ACK);
      @(negedge ref_clk_in);
      xfer_req_in = 1'b1;
      xfer_kind_in = k;
      xfer_mem_in = m;
      wait_cnt = w;
      wait_lvl(0, 1'b1);
      @(posedge ref_clk_in);
      #5;
      chk({addr_latch_out, mem_io_sel_out}, {1'b1, m & !akc});
      chk(xcvr_direction_out, wrc);
      @(negedge ref_clk_in);
      xfer_req_in = 1'b0;
      @(posedge ref_clk_in);
      #5;
      chk({wr_strobe_n_out, irq_ack_strobe_n_out, xcvr_output_enable_n_out},
          {!wrc, !akc, !wrc});
      #10;
      chk(xcvr_output_enable_n_out, 1'b0);
      for (int i = 0; i <= w; i++) begin
         @(posedge ref_clk_in);
         #5;
         chk({irq_ack_strobe_n_out, addr_latch_out}, {!akc, 1'b0});
         if (i > 0) chk(wr_strobe_n_out, !wrc);
      end
      @(posedge ref_clk_in);
      #5;
      chk({wr_strobe_n_out, irq_ack_strobe_n_out, mem_io_sel_out,
           xcvr_output_enable_n_out}, {2'h3, m & !akc, 1'b0});
      #10;
      chk(xcvr_output_enable_n_out, 1'b1);
   endtask
   // Queue events and the code shown one clock later.
   task automatic s_queue();
      logic [2:0] ev [5];
      ev = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h0};
      for (int i = 0; i < 5; i++) begin
         @(negedge ref_clk_in);
         {q_flush_in, q_take_next_in, q_take_first_in} = ev[i];
         @(negedge ref_clk_in);
         {q_flush_in, q_take_next_in, q_take_first_in} = 3'h0;
         chk(queue_track_code_out, ev[i][2] ? 2'h2 : ev[i][0] ? 2'h1 :
             ev[i][1] ? 2'h3 : 2'h0);
      end
   endtask
   // Hold handshake: float, refuse requests, then drive again.
   task automatic s_hold();
      hold_want = 1'b1;
      wait_lvl(1, 1'b1);
      chk({mem_io_sel_oe_out, wr_strobe_n_oe_out, xcvr_direction_oe_out,
           xcvr_output_enable_n_oe_out}, 4'h0);
      chk(addr_latch_out, 1'b0);
      chk(irq_ack_strobe_n_oe_out, 1'b0);
      @(negedge ref_clk_in);
      xfer_req_in = 1'b1;
      repeat (4) begin
         @(negedge ref_clk_in);
         chk(xfer_ack_out, 1'b0);
      end
      // Release with nothing pending: the lines must stay floating.
      hold_want = 1'b0;
      xfer_req_in = 1'b0;
      wait_lvl(1, 1'b0);
      repeat (2) begin
         @(negedge ref_clk_in);
         chk({mem_io_sel_oe_out, wr_strobe_n_oe_out, xcvr_direction_oe_out,
              xcvr_output_enable_n_oe_out}, 4'h0);
      end
      @(negedge ref_clk_in);
      xfer_req_in = 1'b1;
      wait_lvl(0, 1'b1);
      @(posedge ref_clk_in);
      #5;
      chk({mem_io_sel_oe_out, wr_strobe_n_oe_out, xcvr_direction_oe_out,
           xcvr_output_enable_n_oe_out}, 4'hf);
      @(negedge ref_clk_in);
      xfer_req_in = 1'b0;
      repeat (6) @(negedge ref_clk_in);
   endtask
   initial begin
      repeat (10) @(negedge ref_clk_in);
      arst_n_in = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      chk({mode_min_out, mem_io_sel_oe_out, wr_strobe_n_oe_out}, 3'h0);
      arst_n_in = 1'b0;
      config_strap_in = 1'b1;
      repeat (10) @(negedge ref_clk_in);
      arst_n_in = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      chk({mode_min_out, mem_io_sel_oe_out, xcvr_output_enable_n_oe_out},
          3'h7);
      do_cycle(MMB_RD, 1'b1, 4'h0);
      do_cycle(MMB_WR, 1'b1, 4'h2);
      do_cycle(MMB_RD, 1'b0, 4'h1);
      do_cycle(MMB_WR, 1'b0, 4'h0);
      do_cycle(MMB_ACK, 1'b1, 4'h1);
      s_queue();
      s_hold();
      complete_run();
   end
endmodule // test_min_mode_local_bus_control
